/* design/ccr_pkg.sv */
// Contract
// - All control registers are eight bits wide
// - Page bit D0 selects page 0 or 1
// - Reset bit D7 self-clears, zero ignored
// - ADC code divides Fsref by 1 to 6
// - DAC code uses same divisor coding
// - Register 73 holds speaker enable and gain
// - Input pin level readable through register
// - Output pin drives level, clock or interrupt
// - Interrupt sources routed singly or ORed
// - Status register shows interrupt cause
// - Interrupt gives single pulse or pulse train
// - Shorted driver stays off until power cycle
// - Headset type readable at register 13
package ccr_pkg;

   localparam int DW = 8;
   localparam int AW = 7;
   localparam int P1_DEPTH = 128;

   // Register offsets
   localparam logic [AW-1:0] OFF_PAGE = 7'h00;
   localparam logic [AW-1:0] OFF_SWRST = 7'h01;
   localparam logic [AW-1:0] OFF_RATE = 7'h02;
   localparam logic [AW-1:0] OFF_HSTYPE = 7'h0D;
   localparam logic [AW-1:0] OFF_HPPWR = 7'h25;
   localparam logic [AW-1:0] OFF_SCDET = 7'h26;
   localparam logic [AW-1:0] OFF_SPK = 7'h49;
   localparam logic [AW-1:0] OFF_INT_CTRL = 7'h62;
   localparam logic [AW-1:0] OFF_INT_STAT = 7'h63;
   localparam logic [AW-1:0] OFF_GPIO = 7'h64;

   // Field positions
   localparam int PAGE_BIT = 0;
   localparam int SWRST_BIT = 7;
   localparam int ADC_LSB = 4;
   localparam int DAC_LSB = 0;
   localparam int HPPWR_BIT = 7;
   localparam int SC_EN_BIT = 2;
   localparam int SC_AUTO_BIT = 1;
   localparam int SPK_EN_BIT = 7;
   localparam int SPK_GAIN_LSB = 3;
   localparam int INT_TRAIN_BIT = 4;
   localparam int GPIO_MODE_LSB = 4;
   localparam int GPIO_IN_BIT = 1;
   localparam int GPIO_LVL_BIT = 0;

   // Reset values and highest rate code
   localparam logic [DW-1:0] RST_BYTE = 8'h00;
   localparam logic [3:0] RATE_MAX = 4'hA;
   localparam logic [3:0] RATE_ONE_HALVES = 4'h2;

   // Speaker gain, 6 dB steps, fixed gain follows
   localparam int SPK_GAIN_STEP_DB = 6;
   localparam int SPK_GAIN_MAX_DB = 18;
   localparam int SPK_FIXED_DB = 6;

   // GPIO modes
   localparam logic [1:0] GM_INPUT = 2'h0;
   localparam logic [1:0] GM_OUTPUT = 2'h1;
   localparam logic [1:0] GM_CLOCK = 2'h2;
   localparam logic [1:0] GM_IRQ = 2'h3;

   // Timing
   localparam int CLK_MHZ = 40;
   localparam int PULSE_NS = 1000;
   localparam int TRAIN_NS = 4000;
   localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int TRAIN_CYC = TRAIN_NS * CLK_MHZ / 1000;
   localparam int CLKOUT_DIV = 4;
   localparam int CNT_W = 8;

   typedef struct packed {
      logic we;
      logic re;
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
   } ccr_req_t;

   typedef struct packed {
      logic agc_noise;
      logic short_det;
      logic button;
      logic jack;
   } ccr_irq_src_t;

endpackage

/* design/ccr_pulse.sv */
module ccr_pulse import ccr_pkg::*; (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Control
   input wire logic trig,
   input wire logic train,
   input wire logic stop,
   // Pin level
   output logic pulse_q
);

   typedef enum logic [2:0] {
      PS_IDLE = 3'b001,
      PS_HIGH = 3'b010,
      PS_GAP = 3'b100
   } ccr_pstate_t;

   localparam logic [CNT_W-1:0] HIGH_LAST = CNT_W'(PULSE_CYC - 1);
   localparam logic [CNT_W-1:0] GAP_LAST = CNT_W'(TRAIN_CYC - PULSE_CYC - 1);

   ccr_pstate_t st_q;
   logic [CNT_W-1:0] cnt_q;

   // Stop wins so a status read always ends a train
   always_ff @(posedge core_clk) begin
      if (rst || stop) begin
         st_q <= PS_IDLE;
         cnt_q <= '0;
      end else begin
         case (st_q)
            PS_IDLE: begin
               cnt_q <= '0;
               if (trig) begin
                  st_q <= PS_HIGH;
               end
            end
            PS_HIGH: begin
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == HIGH_LAST) begin
                  cnt_q <= '0;
                  st_q <= train ? PS_GAP : PS_IDLE;
               end
            end
            PS_GAP: begin
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == GAP_LAST) begin
                  cnt_q <= '0;
                  st_q <= PS_HIGH;
               end
            end
            default: begin
               st_q <= PS_IDLE;
               cnt_q <= '0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         pulse_q <= 1'b0;
      end else begin
         pulse_q <= (st_q == PS_HIGH) && !stop;
      end
   end

endmodule

/* design/ccr_regs.sv */
module ccr_regs import ccr_pkg::*; (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Control access
   input wire ccr_req_t req,
   output logic [DW-1:0] rd_data_q,
   output logic rd_valid_q,
   // Core status
   input wire logic [1:0] headset_type,
   input wire ccr_irq_src_t irq_src,
   input wire logic hp_short,
   // Codec controls
   output logic [3:0] adc_div_halves_q,
   output logic [3:0] dac_div_halves_q,
   output logic spk_en_q,
   output logic [1:0] spk_gain_q,
   output logic hp_on_q,
   output logic sc_flag_q,
   // General purpose pin
   input wire logic gpio_in,
   output logic gpio_out_q,
   output logic gpio_oe_q
);

   logic page_q;
   logic sw_rst_q;
   logic [DW-1:0] rate_q;
   logic [1:0] hstype_q;
   logic hp_req_q;
   logic hp_down_seen_q;
   logic hp_off_q;
   logic [1:0] sc_ctrl_q;
   logic [DW-1:0] spk_q;
   logic [3:0] int_en_q;
   logic int_train_q;
   logic [3:0] int_stat_q;
   logic [1:0] gpio_mode_q;
   logic gpio_lvl_q;
   logic gpio_in_q;
   logic [CNT_W-1:0] div_cnt_q;
   logic clk_out_q;
   logic [DW-1:0] p1_mem [P1_DEPTH];

   logic clr;
   logic [3:0] src;
   logic [3:0] stat_set;
   logic stat_rd;
   logic irq_pulse;
   logic [DW-1:0] rdata_d;

   localparam logic [CNT_W-1:0] DIV_LAST = CNT_W'(CLKOUT_DIV - 1);

   // Page 0 hit; the page register answers on both pages
   function automatic logic hit0(input logic [AW-1:0] a, input logic pg,
                                 input logic [AW-1:0] off);
      hit0 = (a == off) && (!pg || off == OFF_PAGE);
   endfunction

   function automatic logic wr0(input ccr_req_t r, input logic pg,
                                input logic [AW-1:0] off);
      wr0 = r.we && hit0(r.addr, pg, off);
   endfunction

   // Halves of Fsref divisor, 2 means divide by 1
   function automatic logic [3:0] halves(input logic [3:0] code);
      halves = code + RATE_ONE_HALVES;
   endfunction

   assign clr = rst || sw_rst_q;
   assign src = irq_src;
   assign stat_set = src & int_en_q;
   assign stat_rd = req.re && hit0(req.addr, page_q, OFF_INT_STAT);

   // Soft reset lasts one cycle and clears itself
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sw_rst_q <= 1'b0;
      end else begin
         sw_rst_q <= wr0(req, page_q, OFF_SWRST) && req.wdata[SWRST_BIT];
      end
   end

   always_ff @(posedge core_clk) begin
      if (clr) begin
         page_q <= 1'b0;
      end else if (wr0(req, page_q, OFF_PAGE)) begin
         page_q <= req.wdata[PAGE_BIT];
      end
   end

   // Reserved codes are refused so divisor never exceeds 6
   always_ff @(posedge core_clk) begin
      if (clr) begin
         rate_q <= RST_BYTE;
      end else if (wr0(req, page_q, OFF_RATE)) begin
         if (req.wdata[ADC_LSB +: 4] <= RATE_MAX) begin
            rate_q[ADC_LSB +: 4] <= req.wdata[ADC_LSB +: 4];
         end
         if (req.wdata[DAC_LSB +: 4] <= RATE_MAX) begin
            rate_q[DAC_LSB +: 4] <= req.wdata[DAC_LSB +: 4];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (clr) begin
         adc_div_halves_q <= RATE_ONE_HALVES;
         dac_div_halves_q <= RATE_ONE_HALVES;
      end else begin
         adc_div_halves_q <= halves(rate_q[ADC_LSB +: 4]);
         dac_div_halves_q <= halves(rate_q[DAC_LSB +: 4]);
      end
   end

   always_ff @(posedge core_clk) begin
      if (clr) begin
         hstype_q <= 2'h0;
      end else begin
         hstype_q <= headset_type;
      end
   end

   always_ff @(posedge core_clk) begin
      if (clr) begin
         spk_q <= RST_BYTE;
         spk_en_q <= 1'b0;
         spk_gain_q <= 2'h0;
      end else begin
         if (wr0(req, page_q, OFF_SPK)) begin
            spk_q <= req.wdata;
         end
         spk_en_q <= spk_q[SPK_EN_BIT];
         spk_gain_q <= spk_q[SPK_GAIN_LSB +: 2];
      end
   end

   always_ff @(posedge core_clk) begin
      if (clr) begin
         sc_ctrl_q <= 2'h0;
      end else if (wr0(req, page_q, OFF_SCDET)) begin
         sc_ctrl_q <= {req.wdata[SC_EN_BIT], req.wdata[SC_AUTO_BIT]};
      end
   end

   // Driver power request and the power-down then power-up release
   always_ff @(posedge core_clk) begin
      if (clr) begin
         hp_req_q <= 1'b0;
         hp_down_seen_q <= 1'b0;
      end else if (wr0(req, page_q, OFF_HPPWR)) begin
         hp_req_q <= req.wdata[HPPWR_BIT];
         hp_down_seen_q <= !req.wdata[HPPWR_BIT] || hp_down_seen_q;
         if (req.wdata[HPPWR_BIT] && hp_down_seen_q) begin
            hp_down_seen_q <= 1'b0;
         end
      end
   end

   // A new short wins over the host's release
   always_ff @(posedge core_clk) begin
      if (clr) begin
         sc_flag_q <= 1'b0;
         hp_off_q <= 1'b0;
      end else if (hp_short && sc_ctrl_q[1]) begin
         sc_flag_q <= 1'b1;
         hp_off_q <= hp_off_q || sc_ctrl_q[0];
      end else if (wr0(req, page_q, OFF_HPPWR) && req.wdata[HPPWR_BIT]
                   && hp_down_seen_q) begin
         sc_flag_q <= 1'b0;
         hp_off_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (clr) begin
         hp_on_q <= 1'b0;
      end else begin
         hp_on_q <= hp_req_q && !hp_off_q;
      end
   end

   always_ff @(posedge core_clk) begin
      if (clr) begin
         int_en_q <= 4'h0;
         int_train_q <= 1'b0;
      end else if (wr0(req, page_q, OFF_INT_CTRL)) begin
         int_en_q <= req.wdata[3:0];
         int_train_q <= req.wdata[INT_TRAIN_BIT];
      end
   end

   // Sticky cause bits; a new event beats the clearing read
   always_ff @(posedge core_clk) begin
      if (clr) begin
         int_stat_q <= 4'h0;
      end else begin
         int_stat_q <= (stat_rd ? 4'h0 : int_stat_q) | stat_set;
      end
   end

   ccr_pulse u_pulse (
      .core_clk(core_clk),
      .rst(clr),
      .trig(|stat_set),
      .train(int_train_q),
      .stop(stat_rd),
      .pulse_q(irq_pulse)
   );

   always_ff @(posedge core_clk) begin
      if (clr) begin
         gpio_mode_q <= GM_INPUT;
         gpio_lvl_q <= 1'b0;
      end else if (wr0(req, page_q, OFF_GPIO)) begin
         gpio_mode_q <= req.wdata[GPIO_MODE_LSB +: 2];
         gpio_lvl_q <= req.wdata[GPIO_LVL_BIT];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         gpio_in_q <= 1'b0;
      end else begin
         gpio_in_q <= gpio_in;
      end
   end

   // Internal clock out, an eighth of the core rate
   always_ff @(posedge core_clk) begin
      if (clr) begin
         div_cnt_q <= '0;
         clk_out_q <= 1'b0;
      end else if (div_cnt_q == DIV_LAST) begin
         div_cnt_q <= '0;
         clk_out_q <= !clk_out_q;
      end else begin
         div_cnt_q <= div_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (clr) begin
         gpio_out_q <= 1'b0;
         gpio_oe_q <= 1'b0;
      end else begin
         gpio_oe_q <= gpio_mode_q != GM_INPUT;
         case (gpio_mode_q)
            GM_OUTPUT: gpio_out_q <= gpio_lvl_q;
            GM_CLOCK: gpio_out_q <= clk_out_q;
            GM_IRQ: gpio_out_q <= irq_pulse;
            default: gpio_out_q <= 1'b0;
         endcase
      end
   end

   // Page 1 storage; not cleared by reset to save area
   always_ff @(posedge core_clk) begin
      if (req.we && page_q && req.addr != OFF_PAGE) begin
         p1_mem[req.addr] <= req.wdata;
      end
   end

   always_comb begin
      rdata_d = RST_BYTE;
      if (req.addr == OFF_PAGE) begin
         rdata_d[PAGE_BIT] = page_q;
      end else if (page_q) begin
         rdata_d = p1_mem[req.addr];
      end else begin
         case (req.addr)
            OFF_RATE: rdata_d = rate_q;
            OFF_HSTYPE: rdata_d[1:0] = hstype_q;
            OFF_HPPWR: rdata_d[HPPWR_BIT] = hp_req_q;
            OFF_SCDET: begin
               rdata_d[SC_EN_BIT] = sc_ctrl_q[1];
               rdata_d[SC_AUTO_BIT] = sc_ctrl_q[0];
               rdata_d[0] = sc_flag_q;
            end
            OFF_SPK: rdata_d = spk_q;
            OFF_INT_CTRL: begin
               rdata_d[3:0] = int_en_q;
               rdata_d[INT_TRAIN_BIT] = int_train_q;
            end
            OFF_INT_STAT: rdata_d[3:0] = int_stat_q;
            OFF_GPIO: begin
               rdata_d[GPIO_MODE_LSB +: 2] = gpio_mode_q;
               rdata_d[GPIO_IN_BIT] = gpio_in_q;
               rdata_d[GPIO_LVL_BIT] = gpio_lvl_q;
            end
            default: rdata_d = RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rd_data_q <= RST_BYTE;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= req.re;
         if (req.re) begin
            rd_data_q <= rdata_d;
         end
      end
   end

endmodule

/* verif/ccr_regs_properties.sv */
module ccr_regs_properties import ccr_pkg::*; (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Access
   input wire ccr_req_t req,
   input wire logic rd_valid_q,
   // Controls
   input wire logic [3:0] adc_div_halves_q,
   input wire logic [3:0] dac_div_halves_q,
   input wire logic spk_en_q,
   input wire logic [1:0] spk_gain_q,
   // Interrupt sources and pin
   input wire ccr_irq_src_t irq_src,
   input wire logic gpio_out_q,
   input wire logic gpio_oe_q
);
   timeunit 1ns;
   timeprecision 1ps;
   logic pg_q, irq_q, w0, sr;
   logic [4:0] cfg_q;
   logic [7:0] hi_q, lo_q;
   default clocking
      @(posedge core_clk);
   endclocking
   default disable iff (rst);
   assign w0 = req.we && !pg_q;
   assign sr = w0 && req.addr == OFF_SWRST && req.wdata[SWRST_BIT];
   // Shadow of page, pin mode and irq control
   always_ff @(posedge core_clk) begin
      if (rst || sr) begin
         pg_q <= 1'b0;
         irq_q <= 1'b0;
         cfg_q <= 5'h00;
      end else if (req.we && req.addr == OFF_PAGE) begin
         pg_q <= req.wdata[PAGE_BIT];
      end else if (w0 && req.addr == OFF_GPIO) begin
         irq_q <= req.wdata[5:4] == GM_IRQ;
      end else if (w0 && req.addr == OFF_INT_CTRL) begin
         cfg_q <= req.wdata[4:0];
      end
   end
   // Run lengths of the pin, low side saturates
   always_ff @(posedge core_clk) begin
      if (rst) begin
         hi_q <= 8'h00;
         lo_q <= 8'h00;
      end else begin
         hi_q <= gpio_out_q ? hi_q + 8'h01 : 8'h00;
         lo_q <= gpio_out_q ? 8'h00 : lo_q + {7'h00, lo_q != 8'hFF};
      end
   end
   property p_rd_valid;
      req.re |=> rd_valid_q;
   endproperty
   a_rd_valid: assert property (p_rd_valid) else $error("read answer missing");
   property p_adc_wr;
      w0 && req.addr == OFF_RATE && req.wdata[7:4] <= RATE_MAX
         |-> ##2 adc_div_halves_q == $past(req.wdata[7:4], 2) + 4'h2;
   endproperty
   a_adc_wr: assert property (p_adc_wr) else $error("adc divisor wrong");
   property p_dac_rsv;
      w0 && req.addr == OFF_RATE && req.wdata[3:0] > RATE_MAX |-> ##2 $stable(dac_div_halves_q);
   endproperty
   a_dac_rsv: assert property (p_dac_rsv) else $error("reserved dac code taken");
   property p_spk;
      w0 && req.addr == OFF_SPK |-> ##2 spk_en_q == $past(req.wdata[7], 2)
         && spk_gain_q == $past(req.wdata[4:3], 2);
   endproperty
   a_spk: assert property (p_spk) else $error("speaker control wrong");
   property p_pg1;
      req.we && pg_q && req.addr == OFF_SPK |-> ##2 $stable(spk_en_q) && $stable(spk_gain_q);
   endproperty
   a_pg1: assert property (p_pg1) else $error("page 1 write hit page 0");
   property p_swrst;
      sr |-> ##2 adc_div_halves_q == RATE_ONE_HALVES && !spk_en_q;
   endproperty
   a_swrst: assert property (p_swrst) else $error("soft reset missed");
   property p_oe;
      w0 && req.addr == OFF_GPIO |-> ##2 gpio_oe_q == ($past(req.wdata[5:4], 2) != GM_INPUT);
   endproperty
   a_oe: assert property (p_oe) else $error("pin enable wrong");
   property p_lvl;
      w0 && req.addr == OFF_GPIO && req.wdata[5:4] == GM_OUTPUT
         |-> ##2 gpio_out_q == $past(req.wdata[GPIO_LVL_BIT], 2);
   endproperty
   a_lvl: assert property (p_lvl) else $error("pin level wrong");
   property p_irq;
      irq_q && cfg_q == 5'h0F && irq_src != 4'h0 && lo_q > 8'h04 |-> ##3 gpio_out_q;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt pulse missing");
   property p_len;
      irq_q && $past(irq_q, 2) && $fell(gpio_out_q) |-> hi_q == 8'(PULSE_CYC);
   endproperty
   a_len: assert property (p_len) else $error("pulse width wrong");
   c_rsv: cover property (w0 && req.addr == OFF_RATE && req.wdata[3:0] > RATE_MAX);
   c_train: cover property (cfg_q[INT_TRAIN_BIT] && $rose(gpio_out_q));
   c_pg1: cover property (req.we && pg_q && req.addr != OFF_PAGE);
endmodule

bind ccr_regs ccr_regs_properties CHK (.core_clk(core_clk), .rst(rst), .req(req),
   .rd_valid_q(rd_valid_q), .adc_div_halves_q(adc_div_halves_q),
   .dac_div_halves_q(dac_div_halves_q), .spk_en_q(spk_en_q), .spk_gain_q(spk_gain_q),
   .irq_src(irq_src), .gpio_out_q(gpio_out_q), .gpio_oe_q(gpio_oe_q));

/* verif/ccr_host.sv */
module ccr_host import ccr_pkg::*; (
   // Clock
   input wire logic core_clk,
   // Bus
   output ccr_req_t req,
   input wire logic [DW-1:0] rd_data_q,
   input wire logic rd_valid_q
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [41:0] SEQ_A = {7'h00, 7'h08, 7'h08, 7'h08, 7'h0D, 7'h00};
   localparam logic [47:0] SEQ_D = 48'h005C5D5C0D0D;
   initial req = '0;
   // Released lines show the inverse, not a stale value
   task automatic xfer(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d,
         output logic [DW-1:0] q);
      @(negedge core_clk);
      req <= {w, !w, a, d};
      // Answer stands one cycle only, take it before releasing
      @(negedge core_clk);
      q = rd_valid_q === 1'b1 ? rd_data_q : 8'hXX;
      req <= {2'b00, ~a, ~d};
      @(negedge core_clk);
   endtask
   task automatic set_page(input logic p, output logic [DW-1:0] q);
      xfer(1'b1, OFF_PAGE, {7'h00, p}, q);
      xfer(1'b0, OFF_PAGE, 8'h00, q);
   endtask
   task automatic spk_init;
      logic [DW-1:0] q;
      for (int i = 0; i < 6; i++) begin
         xfer(1'b1, SEQ_A[i*7+:7], SEQ_D[i*8+:8], q);
      end
   endtask
endmodule

/* verif/test_codec_control_regs_gpio_irq.sv */
module test_codec_control_regs_gpio_irq import ccr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, rst, gpio_in, hp_short, rd_valid_q, spk_en_q, hp_on_q, sc_flag_q;
   logic gpio_out_q, gpio_oe_q;
   logic [1:0] headset_type, spk_gain_q;
   logic [3:0] adc_div_halves_q, dac_div_halves_q;
   logic [7:0] rd_data_q, q, v, e;
   ccr_irq_src_t irq_src;
   ccr_req_t req;
   int err_count = 0;
   int checked = 0;
   int n, h;
   ccr_regs DUT (.core_clk(core_clk), .rst(rst), .req(req), .rd_data_q(rd_data_q),
      .rd_valid_q(rd_valid_q), .headset_type(headset_type), .irq_src(irq_src),
      .hp_short(hp_short), .adc_div_halves_q(adc_div_halves_q),
      .dac_div_halves_q(dac_div_halves_q), .spk_en_q(spk_en_q), .spk_gain_q(spk_gain_q),
      .hp_on_q(hp_on_q), .sc_flag_q(sc_flag_q), .gpio_in(gpio_in), .gpio_out_q(gpio_out_q),
      .gpio_oe_q(gpio_oe_q));
   ccr_host HOST (.core_clk(core_clk), .req(req), .rd_data_q(rd_data_q),
      .rd_valid_q(rd_valid_q));
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("checked=%0d err_count=%0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Rises and high cycles of the pin over a window
   task automatic watch(input int c, output int r, output int hc);
      logic p;
      r = 0;
      hc = 0;
      p = gpio_out_q;
      repeat (c) begin
         @(negedge core_clk);
         r += int'(gpio_out_q && !p);
         hc += int'(gpio_out_q);
         p = gpio_out_q;
      end
   endtask
   // Reserved codes leave the old nibble
   function automatic logic [3:0] keep(input logic [3:0] o, input logic [3:0] c);
      return c > RATE_MAX ? o : c;
   endfunction
   // Whole sequence is under two thousand cycles
   initial begin
      #500000;
      err_count++;
      complete_run();
   end
   initial begin
      rst = 1'b1;
      gpio_in = 1'b0;
      hp_short = 1'b0;
      headset_type = 2'b00;
      irq_src = '0;
      n = $urandom(32'hCB583B13);
      repeat (10) @(negedge core_clk);
      rst = 1'b0;
      chk({adc_div_halves_q, dac_div_halves_q}, 8'h22);
      chk({spk_en_q, spk_gain_q, hp_on_q, sc_flag_q, gpio_out_q, gpio_oe_q, 1'b0}, 8'h00);
      HOST.xfer(1'b0, OFF_RATE, 8'h00, q);
      chk(q, RST_BYTE);
      $display("reset test done");
      e = RST_BYTE;
      for (int i = 0; i < 12; i++) begin
         v = i == 0 ? 8'hAB : (i == 1 ? 8'hB9 : 8'($urandom));
         e = {keep(e[7:4], v[7:4]), keep(e[3:0], v[3:0])};
         HOST.xfer(1'b1, OFF_RATE, v, q);
         HOST.xfer(1'b0, OFF_RATE, 8'h00, q);
         chk(q, e);
         chk({adc_div_halves_q, dac_div_halves_q}, {e[7:4] + 4'h2, e[3:0] + 4'h2});
      end
      $display("rate test done");
      HOST.spk_init();
      v = {1'b1, 2'b00, 2'($urandom), 3'b000};
      HOST.xfer(1'b1, OFF_SPK, v, q);
      HOST.xfer(1'b0, OFF_SPK, 8'h00, q);
      chk(q, v);
      HOST.set_page(1'b1, q);
      chk(q, 8'h01);
      HOST.xfer(1'b1, OFF_SPK, 8'h00, q);
      HOST.xfer(1'b0, 7'h08, 8'h00, q);
      chk(q, 8'h5C);
      HOST.set_page(1'b0, q);
      chk(q, 8'h00);
      chk({5'h00, spk_en_q, spk_gain_q}, {5'h01, v[4:3]});
      headset_type = 2'($urandom);
      HOST.xfer(1'b1, OFF_HSTYPE, 8'hFF, q);
      HOST.xfer(1'b0, OFF_HSTYPE, 8'h00, q);
      chk(q, {6'h00, headset_type});
      $display("page test done");
      HOST.xfer(1'b1, OFF_GPIO, 8'h00, q);
      for (int i = 0; i < 2; i++) begin
         gpio_in = i[0];
         repeat (4) @(negedge core_clk);
         HOST.xfer(1'b0, OFF_GPIO, 8'h00, q);
         chk(q & 8'h02, {6'h00, i[0], 1'b0});
      end
      for (int i = 0; i < 2; i++) begin
         HOST.xfer(1'b1, OFF_GPIO, 8'h11 - 8'(i), q);
         chk({6'h00, gpio_oe_q, gpio_out_q}, {7'h01, !i[0]});
      end
      HOST.xfer(1'b1, OFF_GPIO, 8'h20, q);
      watch(16, n, h);
      chk(8'(n), 8'h02);
      $display("pin test done");
      HOST.xfer(1'b1, OFF_INT_CTRL, 8'h0F, q);
      HOST.xfer(1'b1, OFF_GPIO, 8'h30, q);
      for (int i = 0; i < 5; i++) begin
         v = i < 4 ? 8'h01 << i : 8'h05;
         irq_src <= ccr_irq_src_t'(v[3:0]);
         @(negedge core_clk);
         irq_src <= '0;
         watch(60, n, h);
         chk(8'(h), 8'(PULSE_CYC));
         HOST.xfer(1'b0, OFF_INT_STAT, 8'h00, q);
         chk(q, v);
         HOST.xfer(1'b0, OFF_INT_STAT, 8'h00, q);
         chk(q, 8'h00);
      end
      HOST.xfer(1'b1, OFF_INT_CTRL, 8'h1F, q);
      irq_src <= ccr_irq_src_t'(4'h1);
      @(negedge core_clk);
      irq_src <= '0;
      watch(400, n, h);
      chk(8'(n), 8'((400 - 4) / TRAIN_CYC + 1));
      HOST.xfer(1'b0, OFF_INT_STAT, 8'h00, q);
      chk(q, 8'h01);
      watch(400, n, h);
      chk(8'(n), 8'h00);
      $display("interrupt test done");
      HOST.xfer(1'b1, OFF_SCDET, 8'h06, q);
      HOST.xfer(1'b1, OFF_HPPWR, 8'h80, q);
      chk({6'h00, hp_on_q, sc_flag_q}, 8'h02);
      hp_short <= 1'b1;
      repeat (4) @(negedge core_clk);
      hp_short <= 1'b0;
      repeat (4) @(negedge core_clk);
      chk({6'h00, hp_on_q, sc_flag_q}, 8'h01);
      HOST.xfer(1'b1, OFF_HPPWR, 8'h00, q);
      HOST.xfer(1'b1, OFF_HPPWR, 8'h80, q);
      chk({6'h00, hp_on_q, sc_flag_q}, 8'h02);
      $display("short test done");
      HOST.xfer(1'b1, OFF_RATE, 8'h55, q);
      HOST.xfer(1'b1, OFF_SWRST, 8'h00, q);
      HOST.xfer(1'b0, OFF_RATE, 8'h00, q);
      chk(q, 8'h55);
      HOST.xfer(1'b1, OFF_SWRST, 8'h80, q);
      HOST.xfer(1'b0, OFF_RATE, 8'h00, q);
      chk(q, RST_BYTE);
      chk({adc_div_halves_q, dac_div_halves_q}, 8'h22);
      HOST.xfer(1'b1, OFF_SPK, 8'h88, q);
      chk({5'h00, spk_en_q, spk_gain_q}, 8'h05);
      $display("soft reset test done");
      complete_run();
   end
endmodule
